// [slpd_pkg.sv]
// constants and types for the strap latch and local power detect block
`default_nettype none
package slpd_pkg;
	localparam logic [15:0] LPSW_ADDR      = 16'h4134;
	localparam logic [15:0] NONREM_ADDR    = 16'h4135;
	localparam logic [7:0]  LPSW_RESET     = 8'hc1;
	localparam logic [7:0]  LPSW_DYNAMIC   = 8'h41;
	localparam logic [7:0]  NONREM_RESET   = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
	localparam int          INIT_CYCLES    = 4;
	localparam int          NONREM_LSB     = 0;

	typedef struct packed {
		logic       cfgMethodHi;
		logic       cfgMethodLo;
		logic [1:0] nonremovablePortStraps;
		logic       chargingSupportP1;
		logic       portDisableMinus1;
	} slpd_straps_t;

	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} slpd_wr_t;

	typedef enum logic [3:0] {
		ST_INIT   = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_CONFIG = 4'h4,
		ST_RUN    = 4'h8
	} slpd_state_t;
endpackage
`default_nettype wire

// [slpd_strap_latch.sv]
// strap capture, local power detect and power switching control register
// Summary of operation
// - the local supply detect pin is sampled once the INIT_COUNT init cycles after reset release have run, and picks self or bus powered.
// - after configuration the sampled supply detect value stays frozen unless the switching register holds 0x41, which makes it follow the pin.
// - the switching register resets to 0xc1, which keeps the latched power status static.
// - the switching register is written either over the SMBus target port or from OTP contents.
// - with local detect in use the non-removable straps are ignored and an internal register is used.
// - all straps are captured after reset release, on every init cycle and last in the sample state; reset itself clears them to 0.
// - configuration registers return to defaults while the straps are captured.
`timescale 1ns/1ps
`default_nettype none
module slpd_strap_latch
	import slpd_pkg::*;
#(
	parameter int INIT_COUNT = INIT_CYCLES
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire slpd_straps_t strapPins,
	input  wire logic         localSupplyDetect,
	input  wire logic         localDetectUsed,
	input  wire slpd_wr_t     smbWrite,
	input  wire slpd_wr_t     otpWrite,
	input  wire logic [15:0]  readAddr,
	input  wire logic         configDone,
	input  wire logic         hsLink,
	output var  slpd_straps_t strapsLatched,
	output var  logic [1:0]   nonremovablePorts,
	output var  logic         selfPowered,
	output var  logic         pinFunctional,
	output var  logic         configured,
	output var  logic         dynamicSwitching,
	output var  logic [7:0]   localPowerSwitchingCtrl,
	output var  logic [7:0]   readData,
	output var  logic         highSpeedIndicator
);
	localparam int CW = $clog2(INIT_COUNT + 1);
	localparam logic [CW-1:0] COUNT_LAST = CW'(INIT_COUNT - 1);

	slpd_state_t  state;
	slpd_state_t  next_state;
	logic [CW-1:0] initCount;
	logic [CW-1:0] next_initCount;
	slpd_straps_t next_strapsLatched;
	logic [1:0]   next_nonremovablePorts;
	logic         next_selfPowered;
	logic         next_pinFunctional;
	logic         next_configured;
	logic         next_dynamicSwitching;
	logic [7:0]   next_localPowerSwitchingCtrl;
	logic [7:0]   nonremCtrl;
	logic [7:0]   next_nonremCtrl;
	logic [7:0]   next_readData;
	logic         next_highSpeedIndicator;
	logic         writeOpen;
	slpd_wr_t     wr;

	function automatic logic [7:0] readMux(input logic [15:0] a, input logic [7:0] lpsw, input logic [7:0] nr);
		if (a == LPSW_ADDR)
			return lpsw;
		else if (a == NONREM_ADDR)
			return nr;
		else
			return READ_UNMAPPED;
	endfunction

	// one exact code opens dynamic switching, every other value stays static
	function automatic logic isDynamic(input logic [7:0] v);
		return v == LPSW_DYNAMIC;
	endfunction

	always_comb begin
		next_state                   = state;
		next_initCount               = initCount;
		next_strapsLatched           = strapsLatched;
		next_selfPowered             = selfPowered;
		next_pinFunctional           = pinFunctional;
		next_configured              = configured;
		next_localPowerSwitchingCtrl = localPowerSwitchingCtrl;
		next_nonremCtrl              = nonremCtrl;
		// smbus and otp writes are both ignored during init and sample; smbus beats otp on a same-cycle collision
		writeOpen = (state == ST_CONFIG) || (state == ST_RUN);
		wr = smbWrite.write ? smbWrite : otpWrite;
		unique case (state)
			ST_INIT: begin
				// registers to defaults while the straps are taken
				next_localPowerSwitchingCtrl = LPSW_RESET;
				next_nonremCtrl              = NONREM_RESET;
				next_strapsLatched           = strapPins;
				next_pinFunctional           = 1'b0;
				next_configured              = 1'b0;
				if (initCount == COUNT_LAST) begin
					next_state = ST_SAMPLE;
				end else begin
					next_initCount = initCount + CW'(1);
				end
			end
			ST_SAMPLE: begin
				next_strapsLatched = strapPins;
				next_selfPowered   = localSupplyDetect;
				next_pinFunctional = 1'b1;
				next_state         = ST_CONFIG;
			end
			ST_CONFIG: begin
				// supply detect still tracked until configuration closes
				next_selfPowered = localSupplyDetect;
				if (configDone) begin
					next_configured = 1'b1;
					next_state      = ST_RUN;
				end
			end
			ST_RUN: begin
				// frozen unless software opened dynamic switching
				if (isDynamic(localPowerSwitchingCtrl)) begin
					next_selfPowered = localSupplyDetect;
				end
			end
		endcase
		if (writeOpen && wr.write) begin
			if (wr.addr == LPSW_ADDR)
				next_localPowerSwitchingCtrl = wr.data;
			if (wr.addr == NONREM_ADDR)
				next_nonremCtrl = wr.data;
		end
		// pin shared with supply detect, so internal register decides
		next_nonremovablePorts = localDetectUsed ? nonremCtrl[NONREM_LSB +: 2]
			: strapsLatched.nonremovablePortStraps;
		next_dynamicSwitching   = isDynamic(localPowerSwitchingCtrl);
		next_readData           = readMux(readAddr, localPowerSwitchingCtrl, nonremCtrl);
		// polarity follows the method strap that shares the pin
		next_highSpeedIndicator = pinFunctional & (hsLink ^ strapsLatched.cfgMethodHi);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state                   <= ST_INIT;
			initCount               <= '0;
			strapsLatched           <= '0;
			nonremovablePorts       <= 2'h0;
			selfPowered             <= 1'b0;
			pinFunctional           <= 1'b0;
			configured              <= 1'b0;
			dynamicSwitching        <= 1'b0;
			localPowerSwitchingCtrl <= LPSW_RESET;
			nonremCtrl              <= NONREM_RESET;
			readData                <= 8'h00;
			highSpeedIndicator      <= 1'b0;
		end else begin
			state                   <= next_state;
			initCount               <= next_initCount;
			strapsLatched           <= next_strapsLatched;
			nonremovablePorts       <= next_nonremovablePorts;
			selfPowered             <= next_selfPowered;
			pinFunctional           <= next_pinFunctional;
			configured              <= next_configured;
			dynamicSwitching        <= next_dynamicSwitching;
			localPowerSwitchingCtrl <= next_localPowerSwitchingCtrl;
			nonremCtrl              <= next_nonremCtrl;
			readData                <= next_readData;
			highSpeedIndicator      <= next_highSpeedIndicator;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_sample_supply: assert property (state == ST_SAMPLE |=> selfPowered == $past(localSupplyDetect))
		else $error("supply detect not sampled after reset release");
	a_frozen_power: assert property (state == ST_RUN && localPowerSwitchingCtrl != LPSW_DYNAMIC
		|=> $stable(selfPowered))
		else $error("power status moved while static");
	a_dynamic_follow: assert property (state == ST_RUN && localPowerSwitchingCtrl == LPSW_DYNAMIC
		|=> selfPowered == $past(localSupplyDetect))
		else $error("dynamic switching did not follow pin");
	a_ctrl_default: assert property ($rose(state == ST_SAMPLE) |-> localPowerSwitchingCtrl == LPSW_RESET)
		else $error("switching register not at default after init");
	a_write_lands: assert property (writeOpen && smbWrite.write && smbWrite.addr == LPSW_ADDR
		|=> localPowerSwitchingCtrl == $past(smbWrite.data))
		else $error("smbus write to switching register lost");
	a_otp_lands: assert property (writeOpen && !smbWrite.write && otpWrite.write && otpWrite.addr == LPSW_ADDR
		|=> localPowerSwitchingCtrl == $past(otpWrite.data))
		else $error("otp write to switching register lost");
	a_nonrem_source: assert property (localDetectUsed && $stable(localDetectUsed) && $stable(nonremCtrl)
		|=> nonremovablePorts == $past(nonremCtrl[NONREM_LSB +: 2]))
		else $error("non-removable straps used with local detect");
	a_nonrem_strap: assert property (!localDetectUsed
		|=> nonremovablePorts == $past(strapsLatched.nonremovablePortStraps))
		else $error("non-removable straps not used without local detect");
	a_strap_capture: assert property (state == ST_SAMPLE |=> strapsLatched == $past(strapPins))
		else $error("straps not captured at release");
	a_init_defaults: assert property (state == ST_INIT ##1 state == ST_INIT |-> nonremCtrl == NONREM_RESET)
		else $error("registers not defaulted during init");
	a_straps_held: assert property (pinFunctional && state != ST_SAMPLE |=> $stable(strapsLatched))
		else $error("shared pin activity disturbed straps");
	a_init_length: assert property (state == ST_INIT && initCount != COUNT_LAST |=> state == ST_INIT)
		else $error("init shorter than expected");
	a_init_exit: assert property (state == ST_INIT && initCount == COUNT_LAST |=> state == ST_SAMPLE)
		else $error("init did not end in strap sample");
	a_init_start: assert property ($rose(reset_n) |-> state == ST_INIT && initCount == '0)
		else $error("reset release did not start init");
	a_init_refuse: assert property (state == ST_INIT |=> localPowerSwitchingCtrl == LPSW_RESET)
		else $error("switching register moved during init");
	a_dyn_flag: assert property (dynamicSwitching == ($past(localPowerSwitchingCtrl) == LPSW_DYNAMIC))
		else $error("dynamic switching flag out of step with register");
	a_pins_init: assert property (state == ST_INIT |=> !pinFunctional)
		else $error("shared pins functional before capture");
	a_pins_sample: assert property (state == ST_SAMPLE |=> pinFunctional)
		else $error("shared pins not functional after capture");
	// indicator polarity rides on the captured method strap, not on the live pin
	a_hs_polarity: assert property (pinFunctional
		|=> highSpeedIndicator == ($past(hsLink) ^ $past(strapsLatched.cfgMethodHi)))
		else $error("speed indicator polarity wrong");
	a_hs_quiet: assert property (!pinFunctional |=> !highSpeedIndicator)
		else $error("speed indicator driven while pin is a strap");

	c_dynamic_on: cover property (state == ST_RUN && dynamicSwitching ##1 $changed(selfPowered));
	c_config_done: cover property (state == ST_CONFIG ##1 state == ST_RUN);
	c_local_nonrem: cover property (localDetectUsed && configured && nonremovablePorts != 2'h0);
	c_otp_load: cover property (writeOpen && !smbWrite.write && otpWrite.write);
endmodule
`default_nettype wire

// [slpd_board_model.sv]
// board strap resistors, supply pin and bus controller writes
`timescale 1ns/1ps
`default_nettype none
module slpd_board_model
	import slpd_pkg::*;
(
	input  wire logic         clock,
	output var  slpd_straps_t strapPins,
	output var  logic         localSupplyDetect,
	output var  slpd_wr_t     smbWrite,
	output var  slpd_wr_t     otpWrite
);
	initial begin
		strapPins = '0;
		localSupplyDetect = 1'b0;
		smbWrite = '0;
		otpWrite = '0;
	end
	// board levels, changed by the bench off the sampling edge
	task automatic pins(input slpd_straps_t s, input logic p);
		strapPins = s;
		localSupplyDetect = p;
	endtask
	// one-cycle strobe, launched and dropped off the sampling edge
	task automatic wr(input logic otp, input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		if (otp) otpWrite = '{1'b1, a, d};
		else smbWrite = '{1'b1, a, d};
		@(negedge clock);
		otpWrite = '0;
		smbWrite = '0;
	endtask
endmodule
`default_nettype wire

// [slpd_strap_latch_tb.sv]
// self-checking bench for the strap latch block
`timescale 1ns/1ps
`default_nettype none
module slpd_strap_latch_tb;
	import slpd_pkg::*;
	logic clock, reset_n, localDetectUsed, configDone, hsLink, selfPowered, pinFunctional, configured;
	logic dynamicSwitching, highSpeedIndicator, sup;
	logic [15:0] readAddr;
	logic [7:0] ctrl, readData, sel;
	logic [1:0] nonremovablePorts;
	slpd_straps_t strapPins, strapsLatched, st;
	logic localSupplyDetect;
	slpd_wr_t smbWrite, otpWrite;
	logic [7:0] expQ[$];
	int bad_count = 0;
	int checks_done = 0;
	event look;
	slpd_board_model board_inst (.clock(clock), .strapPins(strapPins), .localSupplyDetect(localSupplyDetect),
		.smbWrite(smbWrite), .otpWrite(otpWrite));
	slpd_strap_latch #(.INIT_COUNT(INIT_CYCLES)) slpd_strap_latch_inst (.clock(clock), .reset_n(reset_n),
		.strapPins(strapPins), .localSupplyDetect(localSupplyDetect), .localDetectUsed(localDetectUsed),
		.smbWrite(smbWrite), .otpWrite(otpWrite), .readAddr(readAddr), .configDone(configDone), .hsLink(hsLink),
		.strapsLatched(strapsLatched), .nonremovablePorts(nonremovablePorts), .selfPowered(selfPowered),
		.pinFunctional(pinFunctional), .configured(configured), .dynamicSwitching(dynamicSwitching),
		.localPowerSwitchingCtrl(ctrl), .readData(readData), .highSpeedIndicator(highSpeedIndicator));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic complete_run();
		if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t sel %0d seen %h want %h", $time, sel, seen, want);
		end
	endtask
	task automatic note(input logic [7:0] s, input logic [7:0] v);
		@(negedge clock);
		sel = s;
		expQ.push_back(v);
		->look;
	endtask
	// strap levels applied before release, then the pins turn into busy functional lines
	task automatic boot();
		st = 6'($urandom);
		sup = 1'($urandom);
		@(negedge clock);
		board_inst.pins(st, sup);
		readAddr = LPSW_ADDR;
		reset_n = 1'b0;
		note(0, LPSW_RESET);
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		// init plus sample must be over before the pins turn busy
		repeat (6) @(negedge clock);
		board_inst.pins(~st, sup);
		note(2, {2'b00, st});
		note(2, {2'b00, st});
		note(3, {7'h0, sup});
		note(6, 8'h01);
		note(1, LPSW_RESET);
	endtask
	initial begin
		void'($urandom(32'hacb4));
		{reset_n, localDetectUsed, configDone, hsLink, sel} = '0;
		readAddr = LPSW_ADDR;
		boot();
		note(5, {6'h0, st.nonremovablePortStraps});
		note(4, 8'h00);
		hsLink = 1'b1;
		note(8, {7'h0, ~st.cfgMethodHi});
		configDone = 1'b1;
		@(negedge clock);
		configDone = 1'b0;
		note(7, 8'h01);
		board_inst.pins(~st, ~sup);
		note(3, {7'h0, sup});
		board_inst.wr(1'b0, LPSW_ADDR, LPSW_DYNAMIC);
		note(0, LPSW_DYNAMIC);
		note(4, 8'h01);
		note(3, {7'h0, ~sup});
		board_inst.wr(1'b1, LPSW_ADDR, LPSW_RESET);
		note(0, LPSW_RESET);
		readAddr = 16'h1234;
		note(1, READ_UNMAPPED);
		localDetectUsed = 1'b1;
		board_inst.wr(1'b0, NONREM_ADDR, {6'h0, ~st.nonremovablePortStraps});
		note(5, {6'h0, ~st.nonremovablePortStraps});
		boot();
		note(5, NONREM_RESET);
		repeat (3) @(negedge clock);
		complete_run();
	end
	function automatic logic [7:0] pick(input logic [7:0] s);
		case (s)
			0: return ctrl;
			1: return readData;
			2: return {2'b00, strapsLatched};
			3: return {7'h0, selfPowered};
			4: return {7'h0, dynamicSwitching};
			5: return {6'h0, nonremovablePorts};
			6: return {7'h0, pinFunctional};
			7: return {7'h0, configured};
			default: return {7'h0, highSpeedIndicator};
		endcase
	endfunction
	initial forever begin
		@(look);
		check(pick(sel), expQ.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
